// File: rtl/charger_regs.svh
// Constants of the charger pin control block: timing, limits, register map.
// Assumes a 50 MHz system clock and a 32-bit APB register port.
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH

// ************************************************************
// Timing
// ************************************************************
`define CLK_FREQ_HZ            50000000
`define TICK_US_CYCLES         (`CLK_FREQ_HZ / 1000000)
`define US_PER_MS              1000
`define IRQ_PULSE_US           256
`define SHIP_EXIT_PRESS_MS     1000
`define SYSTEM_RESET_PRESS_MS  16000
`define SWITCH_OFF_RESET_MS    250
`define BLINK_PERIOD_MS        1000
`define BLINK_HALF_MS          (`BLINK_PERIOD_MS / 2)
`define DEBOUNCE_MS            20

// ************************************************************
// Input current limits in mA
// ************************************************************
`define LIMIT_SRC_HIGH_MA      12'd500
`define LIMIT_SRC_LOW_MA       12'd2400
`define LIMIT_STEP_MA          100
`define PG_MIN_LIMIT_MA        12'd30

// ************************************************************
// Register map
// ************************************************************
`define APB_ADDR_W             8
`define OFS_CTRL               8'h00
`define OFS_STATUS             8'h04
`define OFS_IRQ_STATUS         8'h08
`define OFS_IRQ_MASK           8'h0c

`define CTRL_LIMIT_LSB         0
`define CTRL_HOST_VALID_BIT    5
`define CTRL_IND_LSB           6
`define CTRL_CONFIG_BIT        8
`define CTRL_SHIP_ENTER_BIT    9

`define RST_LIMIT_FIELD        5'h00
`define RST_IND_CTRL           2'h0
`define RST_CONFIG             1'b1
`define RST_IRQ_MASK           4'h0

`define IRQ_STATUS_CHG_BIT     0
`define IRQ_FAULT_BIT          1
`define IRQ_SHIP_EXIT_BIT      2
`define IRQ_SYS_RESET_BIT      3
`define IRQ_W                  4

`endif

// File: rtl/charger_pkg.sv
// Types shared by the charger pin control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package charger_pkg;

    // Battery switch and ship mode states
    typedef enum logic [1:0] {
        SW_ON,
        SW_SHIP,
        SW_RESET_OFF
    } switch_state_e;

    typedef logic [15:0] ms_count_t;

endpackage

// File: rtl/timebase_if.sv
// Tick enables passed from the timebase to the other modules.
// Assumes one clock; ticks last one cycle.
`timescale 1ns/1ps
interface timebase_if;
    logic tick_us;
    logic tick_ms;

    modport src (output tick_us, output tick_ms);
    modport dst (input tick_us, input tick_ms);
endinterface

// File: rtl/timebase.sv
// Divider producing 1 us and 1 ms enable pulses.
// Assumes i_clk runs at the rate given by CYCLES_PER_US.
`timescale 1ns/1ps
`include "charger_regs.svh"
module timebase #(
    parameter int unsigned CYCLES_PER_US = `TICK_US_CYCLES,
    parameter int unsigned US_PER_MS     = `US_PER_MS
) (
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_nrst,
    // Ticks
    timebase_if.src    tb
);
    logic [7:0] cyc_cnt;
    logic [9:0] us_cnt;
    logic [7:0] next_cyc_cnt;
    logic [9:0] next_us_cnt;
    logic       next_tick_us;
    logic       next_tick_ms;

    // Divider next values
    always_comb begin
        next_cyc_cnt = cyc_cnt + 8'h01;
        next_us_cnt  = us_cnt;
        next_tick_us = 1'b0;
        next_tick_ms = 1'b0;
        if (cyc_cnt == 8'(CYCLES_PER_US - 1)) begin
            next_cyc_cnt = 8'h00;
            next_tick_us = 1'b1;
            next_us_cnt  = us_cnt + 10'h001;
            if (us_cnt == 10'(US_PER_MS - 1)) begin
                next_us_cnt  = 10'h000;
                next_tick_ms = 1'b1;
            end
        end
    end

    // Divider registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cyc_cnt    <= 8'h00;
            us_cnt     <= 10'h000;
            tb.tick_us <= 1'b0;
            tb.tick_ms <= 1'b0;
        end else begin
            cyc_cnt    <= next_cyc_cnt;
            us_cnt     <= next_us_cnt;
            tb.tick_us <= next_tick_us;
            tb.tick_ms <= next_tick_ms;
        end
    end
endmodule

// File: rtl/debounce.sv
// Level debouncer: output follows input once stable for STABLE_MS ms.
// Assumes the input is synchronous to i_clk.
`timescale 1ns/1ps
`include "charger_regs.svh"
module debounce #(
    parameter int unsigned STABLE_MS   = `DEBOUNCE_MS,
    parameter bit          RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_nrst,
    // Ticks
    timebase_if.dst    tb,
    // Level in and out
    input  wire logic  i_raw,
    output logic       o_level
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_level;

    // Restart whenever input matches output, accept after a stable run
    always_comb begin
        next_cnt   = cnt;
        next_level = o_level;
        if (i_raw == o_level) begin
            next_cnt = 8'h00;
        end else if (tb.tick_ms) begin
            next_cnt = cnt + 8'h01;
            if (cnt == 8'(STABLE_MS - 1)) begin
                next_level = i_raw;
                next_cnt   = 8'h00;
            end
        end
    end

    // Debounce registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt     <= 8'h00;
            o_level <= RESET_LEVEL;
        end else begin
            cnt     <= next_cnt;
            o_level <= next_level;
        end
    end
endmodule

// File: rtl/charger_pin_control_status.sv
// Pin control and status logic of a single-cell charger, with APB registers.
// Assumes synchronous status inputs from the analog side and one 50 MHz clock.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "charger_regs.svh"
module charger_pin_control_status #(
    parameter int unsigned CYCLES_PER_US = `TICK_US_CYCLES,
    parameter int unsigned US_PER_MS     = `US_PER_MS,
    parameter int unsigned IRQ_PULSE_US  = `IRQ_PULSE_US,
    parameter int unsigned SHIP_EXIT_MS  = `SHIP_EXIT_PRESS_MS,
    parameter int unsigned SYS_RESET_MS  = `SYSTEM_RESET_PRESS_MS,
    parameter int unsigned SWITCH_OFF_MS = `SWITCH_OFF_RESET_MS,
    parameter int unsigned BLINK_HALF_MS = `BLINK_HALF_MS,
    parameter int unsigned DEBOUNCE_MS   = `DEBOUNCE_MS
) (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    // APB slave
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [`APB_ADDR_W-1:0]  i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic      [31:0]             o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    // Pins and analog status
    input  wire logic                    i_source_select,
    input  wire logic                    i_charge_enable_n,
    input  wire logic                    i_battery_switch_button_n,
    input  wire logic                    i_input_source_present,
    input  wire logic                    i_battery_present,
    input  wire logic                    i_above_undervoltage_lockout,
    input  wire logic                    i_below_input_overvoltage,
    input  wire logic                    i_above_sleep,
    input  wire logic                    i_charging,
    input  wire logic                    i_charge_done,
    input  wire logic                    i_sleep,
    input  wire logic                    i_fault,
    input  wire logic                    i_battery_temp_sense_ok,
    // Open-drain pin enables, high pulls the pin low
    output logic                         o_power_good_n_oe,
    output logic                         o_charge_status_oe,
    output logic                         o_irq_pulse_n_oe,
    // Power path control
    output logic                         o_charge_enable,
    output logic                         o_battery_switch_on,
    output logic                         o_ship_mode,
    output logic      [11:0]             o_input_limit_ma,
    // Level interrupt
    output logic                         o_irq
);

    // ************************************************************
    // Ticks and debounced inputs
    // ************************************************************
    timebase_if tb ();
    logic btn_raw;
    logic btn_level;
    logic sel_level;

    timebase #(.CYCLES_PER_US(CYCLES_PER_US), .US_PER_MS(US_PER_MS)) u_timebase (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .tb     (tb.src)
    );

    // Unpowered pull-up reads as idle high
    assign btn_raw = i_battery_switch_button_n
                   | ~(i_input_source_present | i_battery_present);

    debounce #(.STABLE_MS(DEBOUNCE_MS), .RESET_LEVEL(1'b1)) u_db_button (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .tb      (tb.dst),
        .i_raw   (btn_raw),
        .o_level (btn_level)
    );

    debounce #(.STABLE_MS(DEBOUNCE_MS), .RESET_LEVEL(1'b1)) u_db_select (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .tb      (tb.dst),
        .i_raw   (i_source_select),
        .o_level (sel_level)
    );

    // Saturating millisecond counter step
    function automatic charger_pkg::ms_count_t inc_sat(input charger_pkg::ms_count_t v);
        inc_sat = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    logic [4:0]           limit_field;
    logic                 host_valid;
    logic [1:0]           ind_ctrl;
    logic                 config_bit;
    logic                 ship_enter;
    logic [`IRQ_W-1:0]    irq_status;
    logic [`IRQ_W-1:0]    irq_mask;
    logic [4:0]           next_limit_field;
    logic                 next_host_valid;
    logic [1:0]           next_ind_ctrl;
    logic                 next_config_bit;
    logic                 next_ship_enter;
    logic [`IRQ_W-1:0]    next_irq_status;
    logic [`IRQ_W-1:0]    next_irq_mask;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic [`IRQ_W-1:0]    events;
    logic [31:0]          ctrl_word;
    logic [31:0]          status_word;

    // Read views
    assign ctrl_word   = {22'h000000, 1'b0, config_bit, ind_ctrl, host_valid, limit_field};
    assign status_word = {26'h0000000, i_fault, sel_level, o_ship_mode,
                          o_battery_switch_on, o_charge_enable, o_power_good_n_oe};

    // APB access, one wait state; events win over clears
    always_comb begin
        next_limit_field = limit_field;
        next_host_valid  = host_valid;
        next_ind_ctrl    = ind_ctrl;
        next_config_bit  = config_bit;
        next_ship_enter  = 1'b0;
        next_irq_status  = irq_status | events;
        next_irq_mask    = irq_mask;
        next_prdata      = o_prdata;
        next_pready      = 1'b0;
        next_pslverr     = 1'b0;
        if (i_psel && i_penable && !o_pready) begin
            next_pready = 1'b1;
            next_prdata = 32'h00000000;
            case (i_paddr)
                `OFS_CTRL: begin
                    next_prdata = ctrl_word;
                    if (i_pwrite) begin
                        next_limit_field = i_pwdata[`CTRL_LIMIT_LSB +: 5];
                        next_host_valid  = 1'b1;
                        next_ind_ctrl    = i_pwdata[`CTRL_IND_LSB +: 2];
                        next_config_bit  = i_pwdata[`CTRL_CONFIG_BIT];
                        next_ship_enter  = i_pwdata[`CTRL_SHIP_ENTER_BIT];
                    end
                end
                `OFS_STATUS: begin
                    next_prdata = status_word;
                end
                `OFS_IRQ_STATUS: begin
                    next_prdata = {28'h0000000, irq_status};
                    if (i_pwrite) begin
                        next_irq_status = (irq_status & ~i_pwdata[`IRQ_W-1:0]) | events;
                    end
                end
                `OFS_IRQ_MASK: begin
                    next_prdata = {28'h0000000, irq_mask};
                    if (i_pwrite) begin
                        next_irq_mask = i_pwdata[`IRQ_W-1:0];
                    end
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            limit_field <= `RST_LIMIT_FIELD;
            host_valid  <= 1'b0;
            ind_ctrl    <= `RST_IND_CTRL;
            config_bit  <= `RST_CONFIG;
            ship_enter  <= 1'b0;
            irq_status  <= 4'h0;
            irq_mask    <= `RST_IRQ_MASK;
            o_prdata    <= 32'h00000000;
            o_pready    <= 1'b0;
            o_pslverr   <= 1'b0;
        end else begin
            limit_field <= next_limit_field;
            host_valid  <= next_host_valid;
            ind_ctrl    <= next_ind_ctrl;
            config_bit  <= next_config_bit;
            ship_enter  <= next_ship_enter;
            irq_status  <= next_irq_status;
            irq_mask    <= next_irq_mask;
            o_prdata    <= next_prdata;
            o_pready    <= next_pready;
            o_pslverr   <= next_pslverr;
        end
    end

    // ************************************************************
    // Battery switch, ship mode and system reset
    // ************************************************************
    charger_pkg::switch_state_e sw_state;
    charger_pkg::switch_state_e next_sw_state;
    charger_pkg::ms_count_t     press_cnt;
    charger_pkg::ms_count_t     off_cnt;
    charger_pkg::ms_count_t     next_press_cnt;
    charger_pkg::ms_count_t     next_off_cnt;
    logic                       held;
    logic                       next_held;
    logic                       ship_exit_evt;
    logic                       sys_reset_evt;

    // Press timing and switch sequencing
    always_comb begin
        next_sw_state  = sw_state;
        next_off_cnt   = off_cnt;
        next_press_cnt = press_cnt;
        next_held      = held;
        ship_exit_evt  = 1'b0;
        sys_reset_evt  = 1'b0;
        if (btn_level) begin
            next_press_cnt = 16'h0000;
            next_held      = 1'b0;
        end else if (tb.tick_ms) begin
            next_press_cnt = inc_sat(press_cnt);
        end
        unique case (sw_state)
            charger_pkg::SW_ON: begin
                if (ship_enter) begin
                    next_sw_state = charger_pkg::SW_SHIP;
                end else if (!btn_level && !held && !i_input_source_present
                             && press_cnt >= 16'(SYS_RESET_MS)) begin
                    next_sw_state = charger_pkg::SW_RESET_OFF;
                    next_off_cnt  = 16'h0000;
                    next_held     = 1'b1;
                    sys_reset_evt = 1'b1;
                end
            end
            charger_pkg::SW_SHIP: begin
                if (!btn_level && !held && press_cnt >= 16'(SHIP_EXIT_MS)) begin
                    next_sw_state = charger_pkg::SW_ON;
                    next_held     = 1'b1;
                    ship_exit_evt = 1'b1;
                end
            end
            charger_pkg::SW_RESET_OFF: begin
                if (tb.tick_ms) begin
                    next_off_cnt = inc_sat(off_cnt);
                    if (off_cnt >= 16'(SWITCH_OFF_MS - 1)) begin
                        next_sw_state = charger_pkg::SW_ON;
                    end
                end
            end
        endcase
    end

    // Switch state flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sw_state  <= charger_pkg::SW_ON;
            press_cnt <= 16'h0000;
            off_cnt   <= 16'h0000;
            held      <= 1'b0;
        end else begin
            sw_state  <= next_sw_state;
            press_cnt <= next_press_cnt;
            off_cnt   <= next_off_cnt;
            held      <= next_held;
        end
    end

    // ************************************************************
    // Status pins, charge enable and interrupt pulse
    // ************************************************************
    logic [11:0]             limit_ma;
    logic                    pg_cond;
    logic                    fault_any;
    logic                    charge_req;
    logic [3:0]              status_vec;
    logic [3:0]              status_prev;
    logic                    fault_prev;
    logic                    status_evt;
    logic                    fault_evt;
    charger_pkg::ms_count_t  blink_cnt;
    charger_pkg::ms_count_t  next_blink_cnt;
    logic                    blink_phase;
    logic                    next_blink_phase;
    logic [9:0]              pulse_cnt;
    logic [9:0]              next_pulse_cnt;
    logic                    next_stat_oe;

    // Limit select, power-good and event detection
    always_comb begin
        limit_ma = sel_level ? `LIMIT_SRC_HIGH_MA : `LIMIT_SRC_LOW_MA;
        if (host_valid) begin
            limit_ma = 12'(limit_field * `LIMIT_STEP_MA);
        end
        pg_cond = i_above_undervoltage_lockout & i_below_input_overvoltage
                & i_above_sleep & (limit_ma > `PG_MIN_LIMIT_MA);
        fault_any  = i_fault | ~i_battery_temp_sense_ok;
        charge_req = config_bit & ~i_charge_enable_n;
        status_vec = {i_charging, i_charge_done, i_sleep, pg_cond};
        status_evt = status_vec != status_prev;
        fault_evt  = fault_any & ~fault_prev;
        events     = {sys_reset_evt, ship_exit_evt, fault_evt, status_evt};
    end

    // Blink timing, status drive and pulse width
    always_comb begin
        next_blink_cnt   = blink_cnt;
        next_blink_phase = blink_phase;
        if (tb.tick_ms) begin
            next_blink_cnt = inc_sat(blink_cnt);
            if (blink_cnt >= 16'(BLINK_HALF_MS - 1)) begin
                next_blink_cnt   = 16'h0000;
                next_blink_phase = ~blink_phase;
            end
        end
        if (ind_ctrl[1]) begin
            next_stat_oe = 1'b0;
        end else if (fault_any && charge_req) begin
            next_stat_oe = blink_phase;
        end else if (i_charging && !i_charge_done && !i_sleep) begin
            next_stat_oe = 1'b1;
        end else begin
            next_stat_oe = 1'b0;
        end
        next_pulse_cnt = pulse_cnt;
        if (|events) begin
            next_pulse_cnt = 10'(IRQ_PULSE_US);
        end else if (tb.tick_us && pulse_cnt != 10'h000) begin
            next_pulse_cnt = pulse_cnt - 10'h001;
        end
    end

    // Output and history flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_prev         <= 4'h0;
            fault_prev          <= 1'b0;
            blink_cnt           <= 16'h0000;
            blink_phase         <= 1'b0;
            pulse_cnt           <= 10'h000;
            o_power_good_n_oe   <= 1'b0;
            o_charge_status_oe  <= 1'b0;
            o_irq_pulse_n_oe    <= 1'b0;
            o_charge_enable     <= 1'b0;
            o_battery_switch_on <= 1'b1;
            o_ship_mode         <= 1'b0;
            o_input_limit_ma    <= `LIMIT_SRC_HIGH_MA;
            o_irq               <= 1'b0;
        end else begin
            status_prev         <= status_vec;
            fault_prev          <= fault_any;
            blink_cnt           <= next_blink_cnt;
            blink_phase         <= next_blink_phase;
            pulse_cnt           <= next_pulse_cnt;
            o_power_good_n_oe   <= pg_cond;
            o_charge_status_oe  <= next_stat_oe;
            o_irq_pulse_n_oe    <= next_pulse_cnt != 10'h000;
            o_charge_enable     <= charge_req & i_battery_temp_sense_ok;
            o_battery_switch_on <= next_sw_state == charger_pkg::SW_ON;
            o_ship_mode         <= next_sw_state == charger_pkg::SW_SHIP;
            o_input_limit_ma    <= limit_ma;
            o_irq               <= |(next_irq_status & next_irq_mask);
        end
    end

endmodule

// File: test/charger_properties.sv
// Checker on the charger block ports.
// Assumes a bind to charger_pin_control_status.
`timescale 1ns/1ps
module charger_properties (
    // Watched ports
    input wire logic i_clk, i_nrst, i_psel, i_penable, i_fault, i_charge_enable_n,
    input wire logic i_above_undervoltage_lockout, o_pready, o_pslverr, o_irq_pulse_n_oe,
    input wire logic o_charge_enable, o_battery_switch_on, o_ship_mode, o_power_good_n_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Access taken, pulse held
    sequence s_take; i_psel && i_penable && !o_pready; endsequence
    sequence s_pulse; o_irq_pulse_n_oe [*8]; endsequence
    property p_ans; s_take |=> o_pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; o_pready |=> !o_pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_err; o_pslverr |-> o_pready; endproperty
    a_err: assert property (p_err) else $error("lone error");
    property p_ship; o_ship_mode |-> !o_battery_switch_on; endproperty
    a_ship: assert property (p_ship) else $error("switch on in ship");
    property p_ce; i_charge_enable_n [*2] |-> !o_charge_enable; endproperty
    a_ce: assert property (p_ce) else $error("charge without pin");
    property p_pg; !i_above_undervoltage_lockout [*2] |-> !o_power_good_n_oe; endproperty
    a_pg: assert property (p_pg) else $error("good in lockout");
    property p_flt; $rose(i_fault) |=> o_irq_pulse_n_oe; endproperty
    a_flt: assert property (p_flt) else $error("no fault pulse");
    property p_wid; $rose(o_irq_pulse_n_oe) |-> s_pulse; endproperty
    a_wid: assert property (p_wid) else $error("short pulse");
endmodule
bind charger_pin_control_status charger_properties i_charger_properties (.*);

// File: test/charger_far_side.sv
// Far side: button with pull-up and host view of the interrupt pin.
// Assumes the device pulls a pin low while its enable is high.
`timescale 1ns/1ps
module charger_far_side (
    // Press and pin enable in, wire levels out
    input  wire logic i_press, i_irq_pulse_n_oe,
    output logic      o_button_n, o_irq_pulse_n
);
    // Pull-ups give idle high
    assign o_button_n    = i_press ? 1'b0 : 1'b1;
    assign o_irq_pulse_n = i_irq_pulse_n_oe ? 1'b0 : 1'b1;
endmodule

// File: test/charger_pin_control_status_tb.sv
// Self-checking bench of the charger block.
// Assumes shortened timing: 1 ms is 8 clocks.
`timescale 1ns/1ps
module charger_pin_control_status_tb;
    logic i_clk = 1'b0, i_nrst, i_psel, i_penable, i_pwrite, i_source_select, i_fault;
    logic i_charge_enable_n, i_battery_switch_button_n, i_input_source_present;
    logic i_battery_present, i_above_undervoltage_lockout, i_below_input_overvoltage;
    logic i_above_sleep, i_charging, i_charge_done, i_sleep, i_battery_temp_sense_ok;
    logic o_pready, o_pslverr, o_irq, o_power_good_n_oe, o_charge_status_oe, s, slv;
    logic o_irq_pulse_n_oe, o_charge_enable, o_battery_switch_on, o_ship_mode, press, irq_n;
    logic [7:0]  i_paddr;
    logic [4:0]  f;
    logic [11:0] o_input_limit_ma;
    logic [31:0] i_pwdata, o_prdata, rd;
    int          err_total, compares, n;
    charger_pin_control_status #(.CYCLES_PER_US(2), .US_PER_MS(4), .IRQ_PULSE_US(8),
        .SHIP_EXIT_MS(10), .SYS_RESET_MS(20), .SWITCH_OFF_MS(5), .BLINK_HALF_MS(4),
        .DEBOUNCE_MS(2)) i_charger_pin_control_status (.*);
    charger_far_side i_charger_far_side (.i_press(press), .i_irq_pulse_n_oe(o_irq_pulse_n_oe),
        .o_button_n(i_battery_switch_button_n), .o_irq_pulse_n(irq_n));
    initial forever #10 i_clk = ~i_clk;
    function logic [31:0] lim(input logic [4:0] v); return v * 100; endfunction
    task cyc(input int k); repeat (k) @(posedge i_clk); endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        {slv, rd} = {o_pslverr, o_prdata};
        {i_psel, i_penable} <= 2'b00;
    endtask
    task results;
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        cyc(20000);
        err_total++;
        results();
    end
    initial begin
        void'($urandom(32'h2a20));
        {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, press, i_charging} = '0;
        {i_charge_done, i_sleep, i_fault} = '0;
        {i_source_select, i_charge_enable_n, i_input_source_present, i_battery_present} = '1;
        {i_above_undervoltage_lockout, i_below_input_overvoltage, i_above_sleep} = '1;
        i_battery_temp_sense_ok = 1'b1;
        cyc(6);
        i_nrst <= 1'b1;
        cyc(2);
        chk(o_input_limit_ma, 32'h1f4);
        // Glitch then held low select
        i_source_select <= 1'b0;
        cyc(4);
        i_source_select <= 1'b1;
        cyc(30);
        chk(o_input_limit_ma, 32'h1f4);
        i_source_select <= 1'b0;
        cyc(40);
        chk(o_input_limit_ma, 32'h960);
        // Host limit, zero limit, unmapped place
        f = 5'($urandom_range(31, 1));
        apb(1'b1, 8'h00, {27'h0, f});
        cyc(2);
        chk(o_input_limit_ma, lim(f));
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h20 | f);
        apb(1'b1, 8'h00, 32'h100);
        cyc(3);
        chk(o_power_good_n_oe, 32'h0);
        apb(1'b1, 8'h00, 32'h114);
        i_above_undervoltage_lockout <= 1'b0;
        cyc(3);
        chk(o_power_good_n_oe, 32'h0);
        i_above_undervoltage_lockout <= 1'b1;
        {i_below_input_overvoltage, i_above_sleep} <= 2'($urandom_range(2, 0));
        cyc(3);
        chk(o_power_good_n_oe, 32'h0);
        {i_below_input_overvoltage, i_above_sleep} <= 2'b11;
        cyc(3);
        chk(o_power_good_n_oe, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({slv, rd[30:0]}, 32'h80000000);
        // Enable pin and temperature window
        i_charge_enable_n <= 1'b0;
        cyc(3);
        chk(o_charge_enable, 32'h1);
        i_battery_temp_sense_ok <= 1'b0;
        cyc(3);
        chk(o_charge_enable, 32'h0);
        i_battery_temp_sense_ok <= 1'b1;
        // Fault pulse, blink, level interrupt
        apb(1'b1, 8'h0c, 32'hf);
        cyc(25);
        apb(1'b1, 8'h08, 32'hf);
        i_fault <= 1'b1;
        cyc(3);
        chk({irq_n, o_irq}, 32'h1);
        s = o_charge_status_oe;
        cyc(32);
        chk({irq_n, o_charge_status_oe}, {30'h0, 1'b1, !s});
        i_fault <= 1'b0;
        apb(1'b1, 8'h08, 32'hf);
        cyc(2);
        chk(o_irq, 32'h0);
        // Status pin codes
        apb(1'b1, 8'h00, 32'h194);
        i_charging <= 1'b1;
        cyc(3);
        chk(o_charge_status_oe, 32'h0);
        apb(1'b1, 8'h00, 32'h114);
        cyc(3);
        chk(o_charge_status_oe, 32'h1);
        i_charge_done <= 1'b1;
        cyc(3);
        chk(o_charge_status_oe, 32'h0);
        {i_charge_done, i_sleep} <= 2'b01;
        cyc(3);
        chk(o_charge_status_oe, 32'h0);
        // Ship mode and exit press
        apb(1'b1, 8'h00, 32'h314);
        cyc(2);
        chk({o_ship_mode, o_battery_switch_on}, 32'h2);
        press <= 1'b1;
        cyc(80);
        chk(o_ship_mode, 32'h1);
        cyc(40);
        chk({o_ship_mode, o_battery_switch_on}, 32'h1);
        press <= 1'b0;
        cyc(30);
        // Long press with no source
        i_input_source_present <= 1'b0;
        press <= 1'b1;
        for (n = 0; n < 400 && o_battery_switch_on; n++) cyc(1);
        chk(n >= 160 && n <= 200, 32'h1);
        for (n = 0; n < 100 && !o_battery_switch_on; n++) cyc(1);
        chk(n >= 32 && n <= 48, 32'h1);
        // No source and no battery: press ignored
        press <= 1'b0;
        cyc(30);
        {i_battery_present, press} <= 2'b01;
        for (n = 0; n < 240 && o_battery_switch_on; n++) cyc(1);
        chk(n, 32'hf0);
        results();
    end
endmodule
